// [rtl/gpl_cfg.svh]
// Register offsets, reset values and field positions of the port block.
// Assumes inclusion by bare name from the design files.
`ifndef GPL_CFG_SVH
`define GPL_CFG_SVH
`define GPL_KEYPAD_DATA_OFF 9'h006
`define GPL_KEYPAD_DATA_ALT 9'h106
`define GPL_PERIPH_DATA_OFF 9'h007
`define GPL_DISPLAY_DATA_OFF 9'h008
`define GPL_INONLY_DATA_OFF 9'h009
`define GPL_OPTION_OFF 9'h081
`define GPL_OPTION_ALT 9'h181
`define GPL_KEYPAD_DIR_OFF 9'h086
`define GPL_KEYPAD_DIR_ALT 9'h186
`define GPL_PERIPH_DIR_OFF 9'h087
`define GPL_DISPLAY_DIR_OFF 9'h088
`define GPL_SEG_EN_OFF 9'h10D
`define GPL_PERIPH_CTRL_OFF 9'h120
`define GPL_OPTION_RST 8'hFF
`define GPL_KEYPAD_DIR_RST 8'hFF
`define GPL_PERIPH_DIR_RST 6'h3F
`define GPL_DISPLAY_DIR_RST 8'hFF
`define GPL_SEG_EN_RST 8'hFF
`define GPL_DISPLAY_DATA_RST 8'h00
`define GPL_PULL_UP_DISABLE_BIT 7
`define GPL_SEG_GRP_0_BIT 0
`define GPL_SEG_GRP_5_BIT 1
`define GPL_SEG_GRP_9_BIT 2
`define GPL_SEG_GRP_27_BIT 6
`define GPL_SEG_GRP_29_BIT 7
`endif

// [rtl/gpl_pkg.sv]
// Types shared by the port block.
// Assumes nothing beyond a SystemVerilog compiler.
package gpl_pkg;
  // Peripheral ownership of the peripheral port pins
  typedef struct packed {
    logic timer_osc;
    logic ccp;
    logic ccp_out;
    logic ssp;
    logic ssp_i2c;
  } gpl_periph_t;
endpackage : gpl_pkg

// [rtl/gpl_ports.sv]
// General-purpose ports: keypad, peripheral, display and input-only display.
// Assumes a single 100 MHz clock, a same-clock register master and pins
// that arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`include "gpl_cfg.svh"
module gpl_ports #(
  parameter int ADDR_W = 9
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_por_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_keypad_pin,
  output logic [7:0] o_keypad_out,
  output logic [7:0] o_keypad_oe,
  output logic [7:0] o_keypad_pull_up,
  input wire logic [5:0] i_periph_pin,
  output logic [5:0] o_periph_out,
  output logic [5:0] o_periph_oe,
  input wire logic i_second_timer_osc_out,
  input wire logic i_capture_compare_pwm_out,
  input wire logic i_ssp_clk_out,
  input wire logic i_ssp_clk_oe,
  input wire logic i_ssp_data_oe,
  input wire logic i_ssp_sdo,
  output logic o_second_timer_clock_in,
  output logic o_capture_compare_pwm_in,
  output logic o_ssp_clk_in,
  output logic o_ssp_data_in,
  input wire logic [7:0] i_display_pin,
  output logic [7:0] o_display_out,
  output logic [7:0] o_display_oe,
  output logic [7:0] o_display_seg_mode,
  input wire logic [7:0] i_input_only_display_pin,
  output logic [7:0] o_input_only_seg_mode,
  output logic o_alt_port_bit7_seg_mode
);
  // The decode compares nine address bits, so a narrower bus cannot work
  if (ADDR_W < 9) begin : g_addr_w_check
    $error("gpl_ports: ADDR_W must be at least 9");
  end

  //////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [7:0] keypad_port_data;
  logic [5:0] peripheral_port_data;
  logic [7:0] display_port_data;
  logic [7:0] option_config;
  logic [7:0] keypad_port_direction;
  logic [5:0] peripheral_port_direction;
  logic [7:0] display_port_direction;
  logic [7:0] segment_pin_enable;
  gpl_pkg::gpl_periph_t periph_ctrl;
  logic [8:0] a;
  assign a = i_addr[8:0];

  // Two-flop synchronisers on every pin input
  logic [7:0] kp_s1, kp_s2, dp_s1, dp_s2, ip_s1, ip_s2;
  logic [5:0] pp_s1, pp_s2;
  always_ff @(posedge i_clk) begin
    kp_s1 <= i_keypad_pin;
    kp_s2 <= kp_s1;
    pp_s1 <= i_periph_pin;
    pp_s2 <= pp_s1;
    dp_s1 <= i_display_pin;
    dp_s2 <= dp_s1;
    ip_s1 <= i_input_only_display_pin;
    ip_s2 <= ip_s1;
  end

  // Keypad latch: only power-on clears it, so any other reset keeps it
  // Writes are ignored while a reset is held, so the latch really stays put
  always_ff @(posedge i_clk) begin
    if (!i_por_b) begin
      keypad_port_data <= 8'h00;
    end else if (i_rst_b && i_wr
                 && (a == `GPL_KEYPAD_DATA_OFF || a == `GPL_KEYPAD_DATA_ALT)) begin
      keypad_port_data <= i_wdata;
    end
  end

  // Peripheral latch also survives ordinary resets
  always_ff @(posedge i_clk) begin
    if (!i_por_b) begin
      peripheral_port_data <= 6'h00;
    end else if (i_rst_b && i_wr && a == `GPL_PERIPH_DATA_OFF) begin
      peripheral_port_data <= i_wdata[5:0];
    end
  end

  // Display latch resets to zero on every reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_por_b) begin
      display_port_data <= `GPL_DISPLAY_DATA_RST;
    end else if (i_wr && a == `GPL_DISPLAY_DATA_OFF) begin
      display_port_data <= i_wdata;
    end
  end

  // Direction, option and segment enable registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_por_b) begin
      keypad_port_direction <= `GPL_KEYPAD_DIR_RST;
      peripheral_port_direction <= `GPL_PERIPH_DIR_RST;
      display_port_direction <= `GPL_DISPLAY_DIR_RST;
      option_config <= `GPL_OPTION_RST;
      segment_pin_enable <= `GPL_SEG_EN_RST;
      periph_ctrl <= '0;
    end else if (i_wr) begin
      if (a == `GPL_KEYPAD_DIR_OFF || a == `GPL_KEYPAD_DIR_ALT) begin
        keypad_port_direction <= i_wdata;
      end
      if (a == `GPL_PERIPH_DIR_OFF) begin
        peripheral_port_direction <= i_wdata[5:0];
      end
      if (a == `GPL_DISPLAY_DIR_OFF) begin
        display_port_direction <= i_wdata;
      end
      if (a == `GPL_OPTION_OFF || a == `GPL_OPTION_ALT) begin
        option_config <= i_wdata;
      end
      if (a == `GPL_SEG_EN_OFF) begin
        segment_pin_enable <= i_wdata;
      end
      if (a == `GPL_PERIPH_CTRL_OFF) begin
        periph_ctrl <= i_wdata[4:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Keypad port: pull-ups drop on outputs
  always_comb begin
    o_keypad_out = keypad_port_data;
    o_keypad_oe = ~keypad_port_direction;
    o_keypad_pull_up = option_config[`GPL_PULL_UP_DISABLE_BIT] ? 8'h00
                       : keypad_port_direction;
  end

  //////////////////////////////////////////////////////////////////////////
  // Peripheral port with per-pin ownership override
  logic [5:0] pp_oe_sw;
  assign pp_oe_sw = ~peripheral_port_direction;
  always_comb begin
    o_periph_out = peripheral_port_data;
    o_periph_oe = pp_oe_sw;
    // Timer oscillator owns bits 0 and 1 as analogue pins, no digital drive
    if (periph_ctrl.timer_osc) begin
      o_periph_oe[1:0] = 2'h0;
    end
    if (periph_ctrl.ccp) begin
      o_periph_out[2] = i_capture_compare_pwm_out;
      o_periph_oe[2] = periph_ctrl.ccp_out;
    end
    if (periph_ctrl.ssp) begin
      o_periph_out[3] = i_ssp_clk_out;
      o_periph_oe[3] = i_ssp_clk_oe;
      o_periph_out[4] = 1'b0; // I2C data drives low only
      o_periph_oe[4] = periph_ctrl.ssp_i2c & i_ssp_data_oe;
      // Serial data out exists in SPI mode only; its direction bit stays
      // with software, and in I2C mode bit 5 is plain general I/O
      if (!periph_ctrl.ssp_i2c) begin
        o_periph_out[5] = i_ssp_sdo;
      end
    end
  end

  // Peripheral inputs see the synchronised pins
  always_comb begin
    o_second_timer_clock_in = pp_s2[0];
    o_capture_compare_pwm_in = pp_s2[2];
    o_ssp_clk_in = pp_s2[3];
    o_ssp_data_in = pp_s2[4];
  end

  // Unused but external oscillator output is passed by analogue path
  logic unused_osc;
  assign unused_osc = i_second_timer_osc_out;

  //////////////////////////////////////////////////////////////////////////
  // Display port: segment enable first, then direction for pins 0-4 only
  logic seg_lo, seg_hi;
  assign seg_lo = segment_pin_enable[`GPL_SEG_GRP_0_BIT];
  assign seg_hi = segment_pin_enable[`GPL_SEG_GRP_29_BIT];
  always_comb begin
    o_display_seg_mode = {{3{seg_hi}}, {5{seg_lo}}};
    o_display_out = display_port_data;
  end

  // Per-pin drive: segment use wins, pins 5-7 have no output driver at all
  for (genvar gi = 0; gi < 8; gi++) begin : g_disp_pin
    if (gi < 5) begin : g_io
      assign o_display_oe[gi] = !seg_lo && !display_port_direction[gi];
    end else begin : g_in
      assign o_display_oe[gi] = 1'b0;
    end
  end

  // Input-only port: bits 0-3 group 5, 4-6 group 9, bit 7 group 27
  always_comb begin
    o_input_only_seg_mode = {segment_pin_enable[`GPL_SEG_GRP_27_BIT],
      {3{segment_pin_enable[`GPL_SEG_GRP_9_BIT]}},
      {4{segment_pin_enable[`GPL_SEG_GRP_5_BIT]}}};
    o_alt_port_bit7_seg_mode = segment_pin_enable[`GPL_SEG_GRP_27_BIT];
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data one cycle after the strobe; pins read as levels
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_por_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (a)
        `GPL_KEYPAD_DATA_OFF, `GPL_KEYPAD_DATA_ALT: o_rdata <= kp_s2;
        `GPL_PERIPH_DATA_OFF: o_rdata <= {2'h0, pp_s2};
        `GPL_DISPLAY_DATA_OFF: o_rdata <= dp_s2 & ~o_display_seg_mode;
        `GPL_INONLY_DATA_OFF: o_rdata <= ip_s2 & ~o_input_only_seg_mode;
        `GPL_OPTION_OFF, `GPL_OPTION_ALT: o_rdata <= option_config;
        `GPL_KEYPAD_DIR_OFF, `GPL_KEYPAD_DIR_ALT: o_rdata <= keypad_port_direction;
        `GPL_PERIPH_DIR_OFF: o_rdata <= {2'h0, peripheral_port_direction};
        `GPL_DISPLAY_DIR_OFF: o_rdata <= display_port_direction;
        `GPL_SEG_EN_OFF: o_rdata <= segment_pin_enable;
        `GPL_PERIPH_CTRL_OFF: o_rdata <= {3'h0, periph_ctrl};
        default: o_rdata <= 8'h00; // Unmapped reads as zero
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks: register bus, read data one cycle after the strobe
  a_pp_upper_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $past(i_rd) && $past(a) == `GPL_PERIPH_DIR_OFF |-> o_rdata[7:6] == 2'h0)
    else $error("peripheral direction upper bits not zero");
  a_pd_upper_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $past(i_rd) && $past(a) == `GPL_PERIPH_DATA_OFF |-> o_rdata[7:6] == 2'h0)
    else $error("peripheral data upper bits not zero");
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  a_seg_mask_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $past(i_rd) && $past(a) == `GPL_DISPLAY_DATA_OFF
      |-> (o_rdata & $past(o_display_seg_mode)) == 8'h00)
    else $error("segment pin read as digital");
  a_inonly_mask_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $past(i_rd) && $past(a) == `GPL_INONLY_DATA_OFF
      |-> (o_rdata & $past(o_input_only_seg_mode)) == 8'h00)
    else $error("input-only segment pin read as digital");

  // Checks: reset values, one edge after the reset is seen
  a_pp_dir_reset: assert property (@(posedge i_clk)
    !i_rst_b |=> peripheral_port_direction == 6'h3F)
    else $error("peripheral direction reset wrong");
  a_pp_dir_por: assert property (@(posedge i_clk)
    !i_por_b |=> peripheral_port_direction == 6'h3F)
    else $error("peripheral direction power-on value wrong");
  a_kp_dir_reset: assert property (@(posedge i_clk)
    !i_rst_b |=> keypad_port_direction == 8'hFF)
    else $error("keypad direction reset wrong");
  a_disp_dir_reset: assert property (@(posedge i_clk)
    !i_rst_b |=> display_port_direction == 8'hFF)
    else $error("display direction reset wrong");
  a_keypad_keep: assert property (@(posedge i_clk)
    i_por_b && !i_rst_b |=> keypad_port_data == $past(keypad_port_data))
    else $error("keypad latch lost on reset");
  a_por_segments: assert property (@(posedge i_clk)
    !i_por_b |=> segment_pin_enable == 8'hFF)
    else $error("segments not set on power-on");
  a_seg_reset: assert property (@(posedge i_clk)
    !i_rst_b |=> segment_pin_enable == 8'hFF)
    else $error("segments not set on reset");

  // Checks: display and input-only ports
  a_seg_blocks_oe: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    seg_lo |-> o_display_oe == 8'h00)
    else $error("segment mode pin driven");
  a_disp_hi_input: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_display_oe[7:5] == 3'h0)
    else $error("display upper pins driven");
  a_disp_dir_follow: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !seg_lo |-> o_display_oe[4:0] == ~display_port_direction[4:0])
    else $error("display direction not followed");
  a_inonly_bit7: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_input_only_seg_mode[7] == o_alt_port_bit7_seg_mode)
    else $error("group 27 pins disagree");

  // Checks: keypad pull-ups
  a_pull_up_out: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_keypad_pull_up & o_keypad_oe) == 8'h00)
    else $error("pull-up on output pin");
  a_pull_up_on: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !option_config[`GPL_PULL_UP_DISABLE_BIT] |-> o_keypad_pull_up == keypad_port_direction)
    else $error("pull-up missing on input pin");
  a_pull_up_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    option_config[`GPL_PULL_UP_DISABLE_BIT] |-> o_keypad_pull_up == 8'h00)
    else $error("pull-up on while disabled");

  // Checks: peripheral overrides of the peripheral port
  a_ccp_override: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    periph_ctrl.ccp |-> o_periph_oe[2] == periph_ctrl.ccp_out)
    else $error("ccp override missing");
  a_ccp_pin_out: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    periph_ctrl.ccp |-> o_periph_out[2] == i_capture_compare_pwm_out)
    else $error("ccp output not on pin");
  a_timer_osc_in: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    periph_ctrl.timer_osc |-> o_periph_oe[1:0] == 2'h0)
    else $error("oscillator pins driven");
  a_ssp_clock_pin: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    periph_ctrl.ssp |-> o_periph_oe[3] == i_ssp_clk_oe && o_periph_out[3] == i_ssp_clk_out)
    else $error("serial clock not on pin");
  a_spi_data_in: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    periph_ctrl.ssp && !periph_ctrl.ssp_i2c |-> !o_periph_oe[4])
    else $error("SPI data input driven");
  a_spi_sdo_out: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    periph_ctrl.ssp && !periph_ctrl.ssp_i2c |-> o_periph_out[5] == i_ssp_sdo)
    else $error("serial data out not on pin");
  a_i2c_open_drain: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    periph_ctrl.ssp && periph_ctrl.ssp_i2c |-> !o_periph_out[4])
    else $error("I2C data driven high");
endmodule : gpl_ports

// [test/gpio_ports_lcd_segment_share_test.sv]
// Self-checking bench for the port block, one task per scenario.
// Assumes the pin model stands between the block's pins and the board.
`timescale 1ns/100ps
module gpio_ports_lcd_segment_share_test;
  logic clk = 0, rst_b = 0, por_b = 0, wr_s = 0, rd_s = 0;
  logic [8:0] addr = 0;
  logic [7:0] wdata = 0, rdata, got, ext = 0, io_pin = 0;
  logic [7:0] kp_pin, kp_out, kp_oe, kp_pu, dp_pin, dp_out, dp_oe, dp_seg, io_seg;
  logic [5:0] pc_pin, pc_out, pc_oe;
  logic ccpo = 0, scko = 0, sck_oe = 0, sdo = 0, alt_seg;
  logic sda_oe = 0, t1ck, ccpi, scki, sdi;
  int n_mismatch = 0, tests_run = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz
  always #5 clk = ~clk;
  gpl_ports uut (.i_clk(clk), .i_rst_b(rst_b), .i_por_b(por_b), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_keypad_pin(kp_pin),
    .o_keypad_out(kp_out), .o_keypad_oe(kp_oe), .o_keypad_pull_up(kp_pu),
    .i_periph_pin(pc_pin), .o_periph_out(pc_out), .o_periph_oe(pc_oe),
    .i_second_timer_osc_out(1'b0), .i_capture_compare_pwm_out(ccpo),
    .i_ssp_clk_out(scko), .i_ssp_clk_oe(sck_oe), .i_ssp_data_oe(sda_oe), .i_ssp_sdo(sdo),
    .o_second_timer_clock_in(t1ck), .o_capture_compare_pwm_in(ccpi), .o_ssp_clk_in(scki),
    .o_ssp_data_in(sdi), .i_display_pin(dp_pin), .o_display_out(dp_out),
    .o_display_oe(dp_oe), .o_display_seg_mode(dp_seg), .i_input_only_display_pin(io_pin),
    .o_input_only_seg_mode(io_seg), .o_alt_port_bit7_seg_mode(alt_seg));
  gpl_pin_model pins (.i_ext(ext), .i_kp_out(kp_out), .i_kp_oe(kp_oe), .i_kp_pu(kp_pu),
    .i_pc_out(pc_out), .i_pc_oe(pc_oe), .i_dp_out(dp_out), .i_dp_oe(dp_oe),
    .o_kp_pin(kp_pin), .o_pc_pin(pc_pin), .o_dp_pin(dp_pin));
  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers: compare, bus cycles, pin settling
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [8:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    got = rdata;
  endtask : rd
  // Two sync flops plus margin
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(9'h087);
    check(got, 8'h3F);
    rd(9'h186);
    check(got, 8'hFF);
    rd(9'h10D);
    check(got, 8'hFF);
    rd(9'h0FF);
    check(got, 8'h00);
    check(dp_seg, 8'hFF);
    check(io_seg, 8'hFF);
    $display("test reset done");
  endtask : t_reset
  task automatic t_periph();
    wr(9'h087, 8'hC0);
    rd(9'h087);
    check(got, 8'h00);
    wr(9'h007, 8'hEA);
    check({2'b00, pc_oe}, 8'h3F);
    settle();
    rd(9'h007);
    check(got, 8'h2A);
    wr(9'h087, 8'h0F);
    @(posedge clk);
    ext <= 8'h05;
    settle();
    rd(9'h007);
    check(got, 8'h25);
    check({4'h0, t1ck, ccpi, scki, sdi}, 8'h0C);
    wr(9'h087, 8'h1F);
    @(posedge clk);
    sdo <= 1'b1;
    scko <= 1'b1;
    sck_oe <= 1'b1;
    wr(9'h120, 8'h02);
    check({pc_oe[5], pc_out[5], pc_oe[3], pc_out[3]}, 8'h0F);
    @(posedge clk);
    sdo <= 1'b0;
    sda_oe <= 1'b1;
    wr(9'h120, 8'h03);
    check({pc_oe[4], pc_out[4], pc_out[5]}, 8'h05);
    @(posedge clk);
    ccpo <= 1'b1;
    wr(9'h120, 8'h0C);
    check({pc_oe[2], pc_out[2]}, 8'h03);
    wr(9'h087, 8'h00);
    wr(9'h120, 8'h10);
    check(pc_oe[1:0], 8'h00);
    wr(9'h120, 8'h00);
    $display("test periph done");
  endtask : t_periph
  task automatic t_display();
    wr(9'h088, 8'h00);
    check(dp_oe, 8'h00);
    wr(9'h10D, 8'h7E);
    check(dp_seg, 8'h00);
    check(dp_oe, 8'h1F);
    wr(9'h008, 8'h15);
    @(posedge clk);
    ext <= 8'hA0;
    settle();
    rd(9'h008);
    check(got, 8'hB5);
    wr(9'h10D, 8'h3A);
    check(io_seg, 8'h0F);
    wr(9'h10D, 8'h38);
    check({io_seg[6:0], alt_seg}, 8'h00);
    @(posedge clk);
    io_pin <= 8'hDA;
    settle();
    rd(9'h009);
    check(got, 8'hDA);
    $display("test display done");
  endtask : t_display
  task automatic t_keypad();
    wr(9'h081, 8'h7F);
    wr(9'h086, 8'h0F);
    check(kp_pu, 8'h0F);
    wr(9'h006, 8'hC3);
    check(kp_out & kp_oe, 8'hC0);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check(kp_out, 8'hC3);
    check(kp_pu, 8'h00);
    rd(9'h086);
    check(got, 8'hFF);
    @(posedge clk);
    por_b <= 1'b0;
    @(posedge clk);
    por_b <= 1'b1;
    #1;
    check(kp_out, 8'h00);
    $display("test keypad done");
  endtask : t_keypad
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Main sequence after 16 reset cycles
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    t_reset();
    t_periph();
    t_display();
    t_keypad();
    finish_test();
  end
  // Hang guard well past the run length
  initial begin
    #500000;
    n_mismatch++;
    finish_test();
  end
endmodule : gpio_ports_lcd_segment_share_test

// [test/gpl_pin_model.sv]
// External pin model: drives port pins from the block or from the board.
// Assumes the bench sets the board level of every pin nobody drives.
`timescale 1ns/100ps
module gpl_pin_model (
  input wire logic [7:0] i_ext,
  input wire logic [7:0] i_kp_out,
  input wire logic [7:0] i_kp_oe,
  input wire logic [7:0] i_kp_pu,
  input wire logic [5:0] i_pc_out,
  input wire logic [5:0] i_pc_oe,
  input wire logic [7:0] i_dp_out,
  input wire logic [7:0] i_dp_oe,
  output logic [7:0] o_kp_pin,
  output logic [5:0] o_pc_pin,
  output logic [7:0] o_dp_pin
);
  // Driven bits follow the block, others float to the board level, keypad pins also pulled high by their pull-up
  assign o_kp_pin = (i_kp_oe & i_kp_out) | (~i_kp_oe & (i_kp_pu | i_ext));
  assign o_pc_pin = (i_pc_oe & i_pc_out) | (~i_pc_oe & i_ext[5:0]);
  assign o_dp_pin = (i_dp_oe & i_dp_out) | (~i_dp_oe & i_ext);
endmodule : gpl_pin_model
